// File: src/vmc_top.sv
/*
 * voltage-mode chopper configuration, regulation and standstill control
 * assumes: classic wishbone master, synchronous inputs, 10 MHz mclk_i
 */
// Summary of operation
// - spread flag 1 disables voltage mode; stored bit xor select pin
// - voltage mode stops while microstep interval is below the limit
// - a zero velocity limit keeps voltage mode at any microstep interval
// - 4-bit cap forms top of 8-bit amplitude cap after switch back
// - autoscale 0 forward velocity scaling, 1 regulated scaling
// - autograd 1 tunes gradient when autoscale is 1, otherwise software gradient is used
// - pwm frequency is 2/1024, 2/683, 2/512 or 2/410 of clock
// - chopper output toggles on every pwm tick, a square wave at half the pwm frequency
// - regulation gradient 1..15 is the regulator step only; forward scaling uses the amplitude gradient
// - offset amplitude feeds scaling and seeds offset tuning
// - gradient amplitude seeds tuning; reset value loadable from otp
// - zero hold current in voltage mode applies standstill option
// - standstill option waits for power-down plus ramp delay
// - signed scaling correction -255..255, frozen in current mode
// - tuned gradient and offset readable as 8-bit monitors
// - off time zero disables driver, otherwise only enables it
// - comparator blanked 16, 24, 32 or 40 clocks
`timescale 1ns/1ps
`include "vmc_map.svh"
module vmc_top
  import vmc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // motion and sensing
  input  wire logic        spread_sel_i,
  input  wire logic [19:0] microstep_interval_i,
  input  wire logic        step_i,
  input  wire logic        current_hi_i,
  // one-time-programmable gradient default
  input  wire logic [7:0]  otp_grad_i,
  input  wire logic        otp_valid_i,
  // bridge side
  output logic             voltage_mode_o,
  output logic             driver_en_o,
  output logic             chop_o,
  output logic             blank_o,
  output logic [7:0]       pwm_amp_o,
  output logic [1:0]       bridge_mode_o
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic        cms_r;
  logic        ascl_r;
  logic        agrd_r;
  logic [19:0] vlim_r;
  logic [3:0]  rgrd_r;
  logic [1:0]  div_r;
  logic [1:0]  sso_r;
  logic [3:0]  cap_r;
  logic [7:0]  ofs_r;
  logic [7:0]  grad_r;
  logic [3:0]  off_r;
  logic [1:0]  blk_r;
  logic [4:0]  hold_r;
  logic [3:0]  ramp_r;
  logic [7:0]  pdn_r;
  logic        otp_pend_r;
  logic [8:0]  scale_r;
  logic [7:0]  tgrad_r;
  logic [7:0]  tofs_r;
  logic        cap_hold_r;
  logic [8:0]  still_cnt_r;
  vmc_stand_t  stand_r;
  vmc_stand_t  stand_nxt;
  wire         pwm_tick;
  wire         blank_w;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr      = req & wb_we_i;
  wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        sel_gc  = (wb_adr_i == `VMC_GLOBAL_CONFIG_ADDR);
  wire        sel_vl  = (wb_adr_i == `VMC_VEL_LIMIT_ADDR);
  wire        sel_pc  = (wb_adr_i == `VMC_PWM_CONFIG_ADDR);
  wire        sel_am  = (wb_adr_i == `VMC_AMPLITUDE_ADDR);
  wire        sel_cc  = (wb_adr_i == `VMC_CHOP_CONFIG_ADDR);
  wire        sel_hc  = (wb_adr_i == `VMC_HOLD_CONFIG_ADDR);
  wire        sel_st  = (wb_adr_i == `VMC_STATUS_ADDR);
  wire        sel_mo  = (wb_adr_i == `VMC_MONITOR_ADDR);
  wire        sel_iv  = (wb_adr_i == `VMC_INTERVAL_ADDR);

  wire [31:0] gc_q = {29'h0, agrd_r, ascl_r, cms_r};
  wire [31:0] vl_q = {12'h000, vlim_r};
  wire [31:0] pc_q = {20'h00000, cap_r, sso_r, div_r, rgrd_r};
  wire [31:0] am_q = {16'h0000, grad_r, ofs_r};
  wire [31:0] cc_q = {26'h0, blk_r, off_r};
  wire [31:0] hc_q = {8'h00, pdn_r, 4'h0, ramp_r, 3'h0, hold_r};
  wire [31:0] st_q = {20'h00000, stand_r == ST_PARK, voltage_mode_o,
                      1'b0, scale_r};
  wire [31:0] mo_q = {16'h0000, tgrad_r, tofs_r};
  wire [31:0] iv_q = {12'h000, microstep_interval_i};

  wire [31:0] gc_w = (gc_q & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] vl_w = (vl_q & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] pc_w = (pc_q & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] am_w = (am_q & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] cc_w = (cc_q & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] hc_w = (hc_q & ~wmask) | (wb_dat_i & wmask);

  wire [31:0] rd_q;
  assign rd_q = sel_gc ? gc_q : sel_vl ? vl_q : sel_pc ? pc_q :
                sel_am ? am_q : sel_cc ? cc_q : sel_hc ? hc_q :
                sel_st ? st_q : sel_mo ? mo_q : sel_iv ? iv_q : 32'h0;

  // ---------------------------------------------------------------
  // mode decision
  // ---------------------------------------------------------------
  wire spread_eff = cms_r ^ spread_sel_i;
  wire too_fast   = (vlim_r != 20'h0) &&
                    (microstep_interval_i < vlim_r);
  wire vm_nxt     = ~spread_eff & ~too_fast;
  wire drv_nxt    = (off_r != 4'h0);
  wire vm_rise    = vm_nxt & ~voltage_mode_o;

  // ---------------------------------------------------------------
  // amplitude
  // ---------------------------------------------------------------
  wire [7:0] grad_use = agrd_r ? tgrad_r : grad_r;
  // zero offset means the current-setting linear term drops out
  wire [8:0] fwd_sum  = (ofs_r == 8'h00) ? {1'b0, grad_use} :
                        ({1'b0, ofs_r} + {1'b0, grad_use});
  wire [9:0] aut_sum  = {2'b00, tofs_r} + {scale_r[8], scale_r};
  wire [7:0] fwd_amp  = fwd_sum[8] ? 8'hFF : fwd_sum[7:0];
  wire [7:0] aut_amp  = aut_sum[9] ? 8'h00 :
                        (aut_sum[8] ? 8'hFF : aut_sum[7:0]);
  wire [7:0] raw_amp  = ascl_r ? aut_amp : fwd_amp;
  wire [7:0] cap_amp  = {cap_r, 4'hF};
  wire [7:0] amp_nxt  = ((cap_hold_r || vm_rise) && raw_amp > cap_amp) ?
                        cap_amp : raw_amp;

  // ---------------------------------------------------------------
  // current regulator, step size from the regulation gradient
  // ---------------------------------------------------------------
  wire       reg_run  = voltage_mode_o & ascl_r & pwm_tick;
  wire [9:0] step_ext = {6'h00, rgrd_r};
  wire [9:0] sc_ext   = {scale_r[8], scale_r};
  wire [9:0] sc_dn    = sc_ext - step_ext;
  wire [9:0] sc_up    = sc_ext + step_ext;
  wire [9:0] sc_try   = current_hi_i ? sc_dn : sc_up;
  wire       sc_lo    = $signed(sc_try) < -10'sd255;
  wire       sc_hi    = $signed(sc_try) > 10'sd255;
  wire [8:0] scale_nxt = sc_lo ? 9'h101 : sc_hi ? 9'h0FF : sc_try[8:0];

  // ---------------------------------------------------------------
  // standstill sequencing
  // ---------------------------------------------------------------
  wire [8:0] still_lim = {1'b0, pdn_r} + {5'h00, ramp_r};
  wire       park_ok   = (hold_r == 5'h00) & voltage_mode_o;
  always_comb begin
    stand_nxt = stand_r;
    case (stand_r)
      ST_RUN: begin
        if (park_ok && !step_i) begin
          stand_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (step_i || !park_ok) begin
          stand_nxt = ST_RUN;
        end else if (still_cnt_r >= still_lim) begin
          stand_nxt = ST_PARK;
        end
      end
      ST_PARK: begin
        if (step_i || !park_ok) begin
          stand_nxt = ST_RUN;
        end
      end
      default: stand_nxt = ST_RUN;
    endcase
  end
  wire [1:0] bridge_nxt = (stand_nxt == ST_PARK) ? sso_r : BR_NORMAL;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  vmc_pwm_div u_div (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .sel_i     (div_r),
    .tick_o    (pwm_tick)
  );
  vmc_blank_tmr u_blank (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (pwm_tick),
    .sel_i     (blk_r),
    .blank_o   (blank_w)
  );

  // ---------------------------------------------------------------
  // bus and configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      cms_r    <= 1'b0;
      ascl_r   <= 1'b0;
      agrd_r   <= 1'b0;
      vlim_r   <= 20'h0;
      rgrd_r   <= `VMC_RGRD_RST;
      div_r    <= 2'h0;
      sso_r    <= 2'h0;
      cap_r    <= `VMC_CAP_RST;
      ofs_r    <= `VMC_OFS_RST;
      grad_r   <= `VMC_GRAD_RST;
      off_r    <= `VMC_OFF_RST;
      blk_r    <= `VMC_BLK_RST;
      hold_r   <= 5'h00;
      ramp_r   <= 4'h0;
      pdn_r    <= 8'h00;
      otp_pend_r <= 1'b1;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_q : 32'h0;
      if (wr && sel_gc) begin
        cms_r  <= gc_w[`VMC_GC_CMS_BIT];
        ascl_r <= gc_w[`VMC_GC_ASCL_BIT];
        agrd_r <= gc_w[`VMC_GC_AGRD_BIT];
      end
      if (wr && sel_vl) begin
        vlim_r <= vl_w[19:0];
      end
      if (wr && sel_pc) begin
        rgrd_r <= pc_w[`VMC_PC_RGRD_LSB +: 4];
        div_r  <= pc_w[`VMC_PC_DIV_LSB +: 2];
        sso_r  <= pc_w[`VMC_PC_SSO_LSB +: 2];
        cap_r  <= pc_w[`VMC_PC_CAP_LSB +: 4];
      end
      // a software write outranks the later otp default
      if (wr && sel_am) begin
        ofs_r      <= am_w[7:0];
        grad_r     <= am_w[15:8];
        otp_pend_r <= 1'b0;
      end else if (otp_pend_r && otp_valid_i) begin
        grad_r     <= otp_grad_i;
        otp_pend_r <= 1'b0;
      end
      if (wr && sel_cc) begin
        off_r <= cc_w[`VMC_CC_OFF_LSB +: 4];
        blk_r <= cc_w[`VMC_CC_BLK_LSB +: 2];
      end
      if (wr && sel_hc) begin
        hold_r <= hc_w[`VMC_HC_HOLD_LSB +: 5];
        ramp_r <= hc_w[`VMC_HC_RAMP_LSB +: 4];
        pdn_r  <= hc_w[`VMC_HC_PDN_LSB +: 8];
      end
    end
  end

  // ---------------------------------------------------------------
  // regulation and tuning
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scale_r <= 9'h000;
      tgrad_r <= 8'h00;
      tofs_r  <= 8'h00;
    end else begin
      // comparator is ignored inside the blank window
      if (reg_run && !blank_w) begin
        scale_r <= scale_nxt;
      end
      if (!agrd_r || !ascl_r) begin
        tgrad_r <= grad_r;
      end else if (reg_run && stand_r == ST_RUN && step_i) begin
        tgrad_r <= scale_r[8] ? tgrad_r - {7'h00, |tgrad_r}
                              : tgrad_r + {7'h00, ~&tgrad_r};
      end
      if (!ascl_r) begin
        tofs_r <= ofs_r;
      end else if (reg_run && stand_r != ST_RUN) begin
        tofs_r <= scale_r[8] ? tofs_r - {7'h00, |tofs_r}
                             : tofs_r + {7'h00, ~&tofs_r};
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs and standstill state
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      voltage_mode_o <= 1'b0;
      driver_en_o    <= 1'b0;
      chop_o         <= 1'b0;
      blank_o        <= 1'b0;
      pwm_amp_o      <= 8'h00;
      bridge_mode_o  <= BR_NORMAL;
      cap_hold_r     <= 1'b0;
      stand_r        <= ST_RUN;
      still_cnt_r    <= 9'h000;
    end else begin
      voltage_mode_o <= vm_nxt;
      driver_en_o    <= drv_nxt;
      chop_o         <= chop_o ^ pwm_tick;
      blank_o        <= blank_w;
      pwm_amp_o      <= amp_nxt;
      bridge_mode_o  <= bridge_nxt;
      stand_r        <= stand_nxt;
      // cap lasts until the next pwm tick after the return to voltage mode
      if (vm_rise) begin
        cap_hold_r <= 1'b1;
      end else if (pwm_tick) begin
        cap_hold_r <= 1'b0;
      end
      if (stand_r != ST_WAIT) begin
        still_cnt_r <= 9'h000;
      end else if (pwm_tick && still_cnt_r != 9'h1FF) begin
        still_cnt_r <= still_cnt_r + 9'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ack_pulse_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  spread_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (cms_r ^ spread_sel_i) |=> !voltage_mode_o)
    else $error("voltage mode while spread flag set");
  vel_limit_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (vlim_r != 20'h0 && microstep_interval_i < vlim_r) |=> !voltage_mode_o)
    else $error("voltage mode above velocity limit");
  zero_limit_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!(cms_r ^ spread_sel_i) && vlim_r == 20'h0) |=> voltage_mode_o)
    else $error("voltage mode lost with zero limit");
  cap_apply_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cap_hold_r |=> pwm_amp_o <= {$past(cap_r), 4'hF})
    else $error("amplitude above cap after switch");
  chop_half_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pwm_tick |=> chop_o != $past(chop_o))
    else $error("chopper output did not toggle");
  scale_freeze_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !voltage_mode_o |=> $stable(scale_r))
    else $error("scaling moved in current mode");
  scale_range_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $signed(scale_r) >= -9'sd255)
    else $error("scaling correction below range");
  driver_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    off_r == 4'h0 |=> !driver_en_o)
    else $error("driver enabled with zero off time");
  park_cond_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    bridge_mode_o != BR_NORMAL |-> stand_r == ST_PARK && $past(hold_r) == 5'h00)
    else $error("standstill option outside park");
  park_wait_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (stand_r == ST_WAIT && stand_nxt == ST_PARK) |-> still_cnt_r >= still_lim)
    else $error("standstill option before delay");
endmodule

// File: src/vmc_map.svh
/*
 * register offsets, field positions, reset values and timing counts
 * assumes: included by bare name from the voltage-mode chopper sources
 */
`ifndef VMC_MAP_SVH
`define VMC_MAP_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define VMC_GLOBAL_CONFIG_ADDR 8'h00
`define VMC_VEL_LIMIT_ADDR     8'h04
`define VMC_INTERVAL_ADDR      8'h08
`define VMC_PWM_CONFIG_ADDR    8'h0C
`define VMC_AMPLITUDE_ADDR     8'h10
`define VMC_CHOP_CONFIG_ADDR   8'h14
`define VMC_HOLD_CONFIG_ADDR   8'h18
`define VMC_STATUS_ADDR        8'h1C
`define VMC_MONITOR_ADDR       8'h20
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define VMC_GC_CMS_BIT   0
`define VMC_GC_ASCL_BIT  1
`define VMC_GC_AGRD_BIT  2
`define VMC_PC_RGRD_LSB  0
`define VMC_PC_DIV_LSB   4
`define VMC_PC_SSO_LSB   6
`define VMC_PC_CAP_LSB   8
`define VMC_CC_OFF_LSB   0
`define VMC_CC_BLK_LSB   4
`define VMC_HC_HOLD_LSB  0
`define VMC_HC_RAMP_LSB  8
`define VMC_HC_PDN_LSB   16
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define VMC_CAP_RST      4'hC
`define VMC_RGRD_RST     4'h1
`define VMC_OFS_RST      8'h00
`define VMC_GRAD_RST     8'h00
`define VMC_OFF_RST      4'h0
`define VMC_BLK_RST      2'h0
// ---------------------------------------------------------------
// timing counts, in system clock periods
// ---------------------------------------------------------------
`define VMC_DIV_P0       11'h400
`define VMC_DIV_P1       11'h2AB
`define VMC_DIV_P2       11'h200
`define VMC_DIV_P3       11'h19A
`define VMC_BLK_BASE     6'h10
`define VMC_BLK_STEP     6'h08
`endif

// File: src/vmc_pkg.sv
/*
 * types shared by the voltage-mode chopper block
 * assumes: compiled before every module of the block
 */
package vmc_pkg;
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_WAIT = 3'b010,
    ST_PARK = 3'b100
  } vmc_stand_t;
  typedef enum logic [1:0] {
    BR_NORMAL = 2'h0,
    BR_FREE   = 2'h1,
    BR_SHORT_LS = 2'h2,
    BR_SHORT_HS = 2'h3
  } vmc_bridge_t;
endpackage

// File: src/vmc_pwm_div.sv
/*
 * pwm period divider: ticks at 2/P of the clock, P chosen by select
 * assumes: single clock, asynchronous active-high reset
 */
`timescale 1ns/1ps
`include "vmc_map.svh"
module vmc_pwm_div
  import vmc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // control
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  logic [10:0] acc_r;
  wire  [10:0] period = (sel_i == 2'h0) ? `VMC_DIV_P0 :
                        (sel_i == 2'h1) ? `VMC_DIV_P1 :
                        (sel_i == 2'h2) ? `VMC_DIV_P2 : `VMC_DIV_P3;
  wire  [10:0] sum    = acc_r + 11'h002;
  // stepping by two gives an exact average rate even for odd periods
  wire         wrap   = (sum >= period);
  wire  [10:0] rem    = sum - period;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_r  <= 11'h000;
      tick_o <= 1'b0;
    end else begin
      // a shorter period chosen mid-run gives one tick and keeps the remainder, or restarts if still out of range; no burst of ticks
      acc_r  <= wrap ? ((rem < period) ? rem : 11'h000) : sum;
      tick_o <= wrap;
    end
  end
  acc_range_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !$changed(sel_i) |-> acc_r < period)
    else $error("divider accumulator out of range");
endmodule

// File: src/vmc_blank_tmr.sv
/*
 * comparator blank timer, 16/24/32/40 clocks after each switching event
 * assumes: single clock, asynchronous active-high reset
 */
`timescale 1ns/1ps
`include "vmc_map.svh"
module vmc_blank_tmr
  import vmc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // control
  input  wire logic       start_i,
  input  wire logic [1:0] sel_i,
  output logic            blank_o
);
  logic [5:0] cnt_r;
  wire  [5:0] len = `VMC_BLK_BASE + 6'(sel_i * `VMC_BLK_STEP);
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= 6'h00;
    end else if (start_i) begin
      cnt_r <= len;
    end else if (cnt_r != 6'h00) begin
      cnt_r <= cnt_r - 6'h01;
    end
  end
  assign blank_o = (cnt_r != 6'h00);
  blank_len_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    start_i |=> cnt_r == $past(len))
    else $error("blank time length wrong");
endmodule

// File: tb/vmc_coil_model.sv
/*
 * coil and bridge model: flags coil current above target to the comparator
 * assumes: amplitude, bridge mode and driver enable come from vmc_top
 */
`timescale 1ns/1ps
module vmc_coil_model
  import vmc_pkg::*;
#(
  parameter logic [7:0] LEVEL = 8'h80
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // bridge drive
  input  wire logic [7:0] amp_i,
  input  wire logic [1:0] bridge_i,
  input  wire logic       drv_en_i,
  // comparator
  output logic            current_hi_o
);
  // ideal plant: no inductive lag, so the regulator settles near LEVEL
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      current_hi_o <= 1'b0;
    end else begin
      current_hi_o <= drv_en_i && (bridge_i == BR_NORMAL) && (amp_i >= LEVEL);
    end
  end
endmodule

// File: tb/vmc_tb_top.sv
/*
 * bench for vmc_top: register bus, mode select, pwm, blanking, amplitude
 * assumes: design sources and the coil model are compiled first
 */
`timescale 1ns/1ps
module voltage_mode_chopper_config_tb_top;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, spread = 1'b0, step = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, rd2;
  logic [19:0] ival = 20'h00000;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, vm, den, chop, blank, chi;
  wire  [7:0]  amp;
  wire  [1:0]  br;
  int          n_fail = 0, check_count = 0, tmo = 0, n, k;
  int          pt[4] = '{1024, 683, 512, 410};

  always #50 mclk_i = ~mclk_i;

  vmc_top i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .spread_sel_i(spread), .microstep_interval_i(ival), .step_i(step),
    .current_hi_i(chi), .otp_grad_i(8'h3C), .otp_valid_i(1'b1), .voltage_mode_o(vm),
    .driver_en_o(den), .chop_o(chop), .blank_o(blank), .pwm_amp_o(amp), .bridge_mode_o(br));

  vmc_coil_model i_coil (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .amp_i(amp), .bridge_i(br),
    .drv_en_i(den), .current_hi_o(chi));

  // ---------------------------------------------------------------
  // bus cycles and checks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic cyc_n(input int c);
    repeat (c) @(posedge mclk_i);
  endtask

  // four chop toggles span exactly two divider periods
  task automatic chop_per(output int c);
    logic p;
    int   t;
    @(posedge mclk_i);
    p = chop;
    while (chop === p) @(posedge mclk_i);
    c = 0; t = 0; p = chop;
    while (t < 4) begin
      @(posedge mclk_i);
      c++;
      if (chop !== p) begin
        t++;
        p = chop;
      end
    end
  endtask

  task automatic blank_w(output int w);
    w = 0;
    @(posedge mclk_i);
    while (blank === 1'b1) @(posedge mclk_i);
    while (blank !== 1'b1) @(posedge mclk_i);
    while (blank === 1'b1) begin
      @(posedge mclk_i);
      w++;
    end
  endtask

  always @(posedge mclk_i) begin
    tmo <= tmo + 1;
    if (tmo == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rdc(8'h0C, 32'h00000C01);
    rdc(8'h14, 32'h0);
    rdc(8'h10, 32'h00003C00);
    rdc(8'h20, 32'h00003C00);
    rdc(8'h40, 32'h0);
    chk(vm, 1'b1);
    for (k = 0; k < 4; k++) begin
      bus(1'b1, 8'h00, {31'h0, k[1]});
      spread <= k[0];
      cyc_n(3);
      chk(vm, !(k[1] ^ k[0]));
    end
    spread <= 1'b0;
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'd100);
    ival <= 20'd99;
    cyc_n(3);
    chk(vm, 1'b0);
    ival <= 20'd100;
    cyc_n(3);
    chk(vm, 1'b1);
    bus(1'b1, 8'h04, 32'h0);
    ival <= 20'd1;
    cyc_n(3);
    chk(vm, 1'b1);
    bus(1'b1, 8'h14, 32'h0);
    chk(den, 1'b0);
    bus(1'b1, 8'h14, 32'h0F);
    cyc_n(2);
    chk(den, 1'b1);
    for (k = 0; k < 4; k++) begin
      bus(1'b1, 8'h0C, {20'h0, 4'hC, 2'b00, k[1:0], 4'h1});
      bus(1'b1, 8'h14, {26'h0, k[1:0], 4'h1});
      chop_per(n);
      chop_per(n);
      chk(n, 2 * pt[k]);
      blank_w(n);
      chk(n, 16 + 8 * k);
    end
    bus(1'b1, 8'h10, 32'h0900);
    cyc_n(300);
    chk(amp, 8'h09);
    bus(1'b1, 8'h10, 32'h0403);
    bus(1'b1, 8'h00, 32'h4);
    cyc_n(300);
    chk(amp, 8'h07);
    rdc(8'h20, 32'h0403);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0C, 32'h0531);
    bus(1'b1, 8'h10, 32'hFFFF);
    cyc_n(300);
    chk(amp, 8'hFF);
    bus(1'b1, 8'h00, 32'h1);
    cyc_n(3);
    bus(1'b1, 8'h00, 32'h0);
    cyc_n(2);
    chk(amp, 8'h5F);
    cyc_n(300);
    chk(amp, 8'hFF);
    bus(1'b1, 8'h10, 32'h0403);
    bus(1'b1, 8'h18, 32'h00020100);
    for (k = 1; k < 4; k++) begin
      bus(1'b1, 8'h0C, {20'h0, 4'hC, k[1:0], 2'b11, 4'h1});
      step <= 1'b1;
      @(posedge mclk_i);
      step <= 1'b0;
      cyc_n(300);
      chk(br, 2'h0);
      cyc_n(900);
      chk(br, k[1:0]);
      step <= 1'b1;
      cyc_n(2);
      chk(br, 2'h0);
      step <= 1'b0;
    end
    bus(1'b1, 8'h00, 32'h1);
    cyc_n(1200);
    chk(br, 2'h0);
    // regulation run with a held current so standstill stays out of it
    bus(1'b1, 8'h18, 32'h1);
    bus(1'b1, 8'h0C, 32'h0C34);
    bus(1'b1, 8'h10, 32'h0040);
    bus(1'b1, 8'h00, 32'h2);
    cyc_n(8000);
    chk({amp >= 8'h78 && amp <= 8'h88}, 1'b1);
    bus(1'b0, 8'h1C, 32'h0);
    chk({rd[8:0] == 9'h03C || rd[8:0] == 9'h040}, 1'b1);
    chk({rd[10], rd[1:0]}, 3'b100);
    bus(1'b1, 8'h00, 32'h3);
    cyc_n(3);
    bus(1'b0, 8'h1C, 32'h0);
    rd2 = rd;
    cyc_n(2000);
    rdc(8'h1C, rd2 & 32'h1FF);
    give_verdict();
  end
endmodule
